// ==== hw/otpp_pkg.sv ====
// Constants and carrier types for the program memory programming port.
// Assumes one 10 MHz clock and an AXI4-Lite master with 32-bit data.
package otpp_pkg;
  // ----------------------------------------------------------------
  // Memory geometry
  // ----------------------------------------------------------------
  localparam int unsigned OTPP_WORDS      = 1002;
  localparam int unsigned OTPP_WORD_W     = 10;
  localparam int unsigned OTPP_ADDR_W     = 10;
  localparam int unsigned OTPP_PORT_W     = 8;
  localparam logic [9:0]  OTPP_TEST_BASE  = 10'h3ea;
  localparam logic [9:0]  OTPP_TEST_LAST  = 10'h3ff;
  localparam logic [9:0]  OTPP_RESTART    = 10'h000;
  localparam logic [1:0]  OTPP_LAST_PULSE = 2'h3;
  localparam logic [9:0]  OTPP_ERASED     = 10'h000;

  // ----------------------------------------------------------------
  // Mode pin patterns, bit n is mode pin n
  // ----------------------------------------------------------------
  localparam logic [3:0] OTPP_MD_CLEAR   = 4'h5;
  localparam logic [3:0] OTPP_MD_WRITE   = 4'he;
  localparam logic [3:0] OTPP_MD_VERIFY  = 4'hc;
  localparam logic [3:0] OTPP_MD_INH_MSK = 4'hd;
  localparam logic [3:0] OTPP_MD_INH_VAL = 4'hd;

  typedef enum logic [2:0] {
    OTPP_M_IDLE    = 3'b000,
    OTPP_M_CLEAR   = 3'b001,
    OTPP_M_WRITE   = 3'b010,
    OTPP_M_VERIFY  = 3'b011,
    OTPP_M_INHIBIT = 3'b100
  } otpp_mode_t;

  typedef enum logic [1:0] {
    OTPP_S_WAIT  = 2'b00,
    OTPP_S_ARMED = 2'b01,
    OTPP_S_PROG  = 2'b10
  } otpp_state_t;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OTPP_OFS_CTRL    = 8'h00;
  localparam logic [7:0] OTPP_OFS_STATUS  = 8'h04;
  localparam logic [7:0] OTPP_OFS_ADDR    = 8'h08;
  localparam logic [7:0] OTPP_OFS_CAPTURE = 8'h0c;
  localparam int unsigned OTPP_CTRL_CAP_EN = 0;
  localparam int unsigned OTPP_ST_MODE_LSB = 0;
  localparam int unsigned OTPP_ST_STATE    = 4;
  localparam int unsigned OTPP_ST_OSC_OK   = 8;
  localparam int unsigned OTPP_ST_OVERRUN  = 9;
  localparam int unsigned OTPP_ADDR_SUB    = 16;
  localparam int unsigned OTPP_CAP_VALID   = 31;
  localparam logic        OTPP_CTRL_RESET  = 1'b0;
  localparam logic [1:0]  OTPP_RESP_OKAY   = 2'b00;
  localparam logic [1:0]  OTPP_RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint OTPP_CLK_HZ     = 10_000_000;
  localparam longint OTPP_HOLD_US    = 2000;
  localparam longint OTPP_HOLD_CYC   = (OTPP_HOLD_US * OTPP_CLK_HZ) / 1_000_000;
  localparam longint OTPP_OSC_TO_NS  = 1000;
  localparam logic [3:0] OTPP_OSC_CYC =
    4'((OTPP_OSC_TO_NS * OTPP_CLK_HZ) / 1_000_000_000);

  typedef struct packed {
    logic [9:0] addr;
    logic [9:0] data;
  } otpp_cap_t;
endpackage

// ==== hw/otpp_port.sv ====
// Programming and verify port of the one-time program memory, with CPU
// fetch guard and an AXI4-Lite register view.
// Assumes all pins already synchronous to clk_in.
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps

module otpp_fifo #(
  parameter int unsigned WIDTH = 20,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  if (DEPTH < 2) $error("otpp_fifo needs DEPTH of 2 or more");
  logic [WIDTH-1:0] slot [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = slot[rd_ptr];

  always_ff @(posedge clk_in) begin
    if (push) begin
      slot[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

module otpp_port
  import otpp_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = 32'(OTPP_HOLD_CYC),
  parameter int unsigned CAP_DEPTH   = 2
) (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // Programming pins
  input  wire logic [3:0]  prog_mode_select_in,
  input  wire logic [7:0]  prog_data_port_in,
  output logic [7:0]       prog_data_port_out,
  output logic             prog_data_port_oe_out,
  input  wire logic        adv_clk_in,
  input  wire logic        vdd_raised_in,
  input  wire logic        vpp_raised_in,
  input  wire logic        resonator_in,
  output logic             resonator_out,
  output logic             prog_active_out,
  // CPU fetch side
  input  wire logic [9:0]  cpu_pc_in,
  output logic [9:0]       cpu_instr_out,
  output logic             cpu_redirect_out,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  if (HOLD_CYCLES < 1 || CAP_DEPTH < 2) $error("otpp_port parameters out of range");

  logic [9:0]  mem [OTPP_WORDS];
  otpp_state_t state;
  otpp_mode_t  mode;
  logic [31:0] hold_cnt;
  logic [9:0]  addr;
  logic [1:0]  sub_cnt;
  logic        adv_prev;
  logic        res_prev;
  logic [3:0]  osc_cnt;
  logic        osc_ok;
  logic        cap_en;
  logic        overrun;
  otpp_cap_t   cap_word;
  logic        cap_pend;
  logic        cap_ready;
  otpp_cap_t   cap_head;
  logic        cap_valid;
  logic        cap_pop;

  // ----------------------------------------------------------------
  // Mode decode and entry sequence
  // ----------------------------------------------------------------
  always_comb begin
    mode = OTPP_M_IDLE;
    if (state == OTPP_S_PROG) begin
      if (prog_mode_select_in == OTPP_MD_CLEAR) begin
        mode = OTPP_M_CLEAR;
      end else if (prog_mode_select_in == OTPP_MD_WRITE) begin
        mode = OTPP_M_WRITE;
      end else if (prog_mode_select_in == OTPP_MD_VERIFY) begin
        mode = OTPP_M_VERIFY;
      end else if ((prog_mode_select_in & OTPP_MD_INH_MSK) == OTPP_MD_INH_VAL) begin
        mode = OTPP_M_INHIBIT;
      end
    end
  end

  wire raised = vdd_raised_in && vpp_raised_in;
  wire quiet  = !vdd_raised_in && !vpp_raised_in;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state    <= OTPP_S_WAIT;
      hold_cnt <= '0;
    end else begin
      unique case (state)
        OTPP_S_WAIT: begin
          if (!quiet) begin
            hold_cnt <= '0;
          end else if (hold_cnt == HOLD_CYCLES - 1) begin
            state <= OTPP_S_ARMED;
          end else begin
            hold_cnt <= hold_cnt + 1'b1;
          end
        end
        OTPP_S_ARMED: begin
          if (raised) begin
            state <= OTPP_S_PROG;
          end
        end
        OTPP_S_PROG: begin
          if (!raised) begin
            state    <= OTPP_S_WAIT;
            hold_cnt <= '0;
          end
        end
        default: begin
          state <= OTPP_S_WAIT;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Address counter stepped by advance pulses
  // ----------------------------------------------------------------
  wire adv_edge = adv_clk_in && !adv_prev;
  wire step     = adv_edge && (mode != OTPP_M_CLEAR) && (state == OTPP_S_PROG)
                  && (sub_cnt == OTPP_LAST_PULSE);

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      adv_prev <= 1'b0;
      addr     <= OTPP_RESTART;
      sub_cnt  <= '0;
    end else begin
      adv_prev <= adv_clk_in;
      if (mode == OTPP_M_CLEAR) begin
        addr    <= OTPP_RESTART;
        sub_cnt <= '0;
      end else if (adv_edge && state == OTPP_S_PROG) begin
        sub_cnt <= sub_cnt + 1'b1;
        if (sub_cnt == OTPP_LAST_PULSE) begin
          addr <= addr + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Resonator activity monitor
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      res_prev      <= 1'b0;
      osc_cnt       <= '0;
      osc_ok        <= 1'b0;
      resonator_out <= 1'b1;
    end else begin
      res_prev      <= resonator_in;
      resonator_out <= !resonator_in;
      if (resonator_in != res_prev) begin
        osc_cnt <= OTPP_OSC_CYC;
        osc_ok  <= 1'b1;
      end else if (osc_cnt != '0) begin
        osc_cnt <= osc_cnt - 1'b1;
      end else begin
        osc_ok <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Cell array: erased cells read 0, writes only set bits
  // ----------------------------------------------------------------
  wire in_range = (addr < 10'(OTPP_WORDS));

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < OTPP_WORDS; i++) begin
        mem[i] <= OTPP_ERASED;
      end
    end else if (mode == OTPP_M_WRITE && osc_ok && in_range) begin
      if (sub_cnt == 2'h0) begin
        mem[addr][7:0] <= mem[addr][7:0] | prog_data_port_in;
      end else begin
        mem[addr][9:8] <= mem[addr][9:8] | prog_data_port_in[1:0];
      end
    end
  end

  wire [9:0] cur_word = in_range ? mem[addr] : OTPP_ERASED;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prog_data_port_out    <= '0;
      prog_data_port_oe_out <= 1'b0;
      prog_active_out       <= 1'b0;
    end else begin
      prog_active_out       <= (state == OTPP_S_PROG);
      prog_data_port_oe_out <= (mode == OTPP_M_VERIFY);
      prog_data_port_out    <= (sub_cnt == 2'h0) ? cur_word[7:0]
                                                 : {6'h00, cur_word[9:8]};
    end
  end

  // ----------------------------------------------------------------
  // CPU fetch with test area guard
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cpu_instr_out    <= '0;
      cpu_redirect_out <= 1'b0;
    end else begin
      cpu_redirect_out <= (cpu_pc_in >= OTPP_TEST_BASE);
      cpu_instr_out    <= (cpu_pc_in < OTPP_TEST_BASE) ? mem[cpu_pc_in] : OTPP_ERASED;
    end
  end

  // ----------------------------------------------------------------
  // Verify capture stream into the two-entry buffer
  // ----------------------------------------------------------------
  wire cap_take = (mode == OTPP_M_VERIFY) && cap_en && step;
  wire ovr_set  = cap_take && cap_pend && !cap_ready;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cap_pend <= 1'b0;
      cap_word <= '0;
    end else if (cap_take && (!cap_pend || cap_ready)) begin
      cap_pend      <= 1'b1;
      cap_word.addr <= addr;
      cap_word.data <= cur_word;
    end else if (cap_ready) begin
      cap_pend <= 1'b0;
    end
  end

  otpp_fifo #(
    .WIDTH ($bits(otpp_cap_t)),
    .DEPTH (CAP_DEPTH)
  ) u_cap (
    .clk_in    (clk_in),
    .nrst_in   (nrst_in),
    .in_data   (cap_word),
    .in_valid  (cap_pend),
    .in_ready  (cap_ready),
    .out_data  (cap_head),
    .out_valid (cap_valid),
    .out_ready (cap_pop)
  );

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  wire rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  wire wr_hit = (s_axi_awaddr == OTPP_OFS_CTRL) || (s_axi_awaddr == OTPP_OFS_STATUS);
  assign cap_pop = rd_go && (s_axi_araddr == OTPP_OFS_CAPTURE) && cap_valid;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= OTPP_RESP_OKAY;
      cap_en        <= OTPP_CTRL_RESET;
      overrun       <= 1'b0;
    end else begin
      s_axi_awready <= wr_go;
      s_axi_wready  <= wr_go;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? OTPP_RESP_OKAY : OTPP_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == OTPP_OFS_CTRL) begin
        cap_en <= s_axi_wdata[OTPP_CTRL_CAP_EN];
      end
      if (ovr_set) begin
        overrun <= 1'b1;
      end else if (wr_go && s_axi_wstrb[1] && s_axi_awaddr == OTPP_OFS_STATUS
                   && s_axi_wdata[OTPP_ST_OVERRUN]) begin
        overrun <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= OTPP_RESP_OKAY;
    end else begin
      s_axi_arready <= rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= OTPP_RESP_OKAY;
        s_axi_rdata  <= '0;
        unique case (s_axi_araddr)
          OTPP_OFS_CTRL:    s_axi_rdata[OTPP_CTRL_CAP_EN] <= cap_en;
          OTPP_OFS_STATUS: begin
            s_axi_rdata[OTPP_ST_MODE_LSB +: 3] <= mode;
            s_axi_rdata[OTPP_ST_STATE +: 2]    <= state;
            s_axi_rdata[OTPP_ST_OSC_OK]        <= osc_ok;
            s_axi_rdata[OTPP_ST_OVERRUN]       <= overrun;
          end
          OTPP_OFS_ADDR: begin
            s_axi_rdata[9:0]                  <= addr;
            s_axi_rdata[OTPP_ADDR_SUB +: 2]   <= sub_cnt;
          end
          OTPP_OFS_CAPTURE: begin
            s_axi_rdata[19:0]           <= cap_head;
            s_axi_rdata[OTPP_CAP_VALID] <= cap_valid;
          end
          default:          s_axi_rresp <= OTPP_RESP_SLVERR;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  sequence four_steps_s;
    adv_edge && sub_cnt == OTPP_LAST_PULSE && mode != OTPP_M_CLEAR
      && state == OTPP_S_PROG;
  endsequence

  addr_step_a: assert property (four_steps_s |=> addr == $past(addr) + 10'h001)
    else $error("address did not step after four pulses");
  addr_still_a: assert property (!adv_edge && mode != OTPP_M_CLEAR |=> $stable(addr))
    else $error("address moved without advance pulse");
  clear_sub_a: assert property (mode == OTPP_M_CLEAR |=> addr == '0 && sub_cnt == '0)
    else $error("clear left address or sub count");
  guard_redir_a: assert property (nrst_in && cpu_pc_in >= OTPP_TEST_BASE
                                  |=> cpu_redirect_out && cpu_instr_out == OTPP_ERASED)
    else $error("test area fetch not redirected");
  entry_order_a: assert property ($rose(state == OTPP_S_PROG) |->
                                  $past(state) == OTPP_S_ARMED && $past(raised))
    else $error("program mode entered out of order");
  inhibit_dec_a: assert property (state == OTPP_S_PROG && prog_mode_select_in[0]
                                  && prog_mode_select_in[3:2] == 2'b11 |-> mode == OTPP_M_INHIBIT)
    else $error("inhibit pattern misdecoded");
  verify_dec_a: assert property (state == OTPP_S_PROG && prog_mode_select_in == OTPP_MD_VERIFY
                                 |=> prog_data_port_oe_out)
    else $error("verify pattern did not drive port");
  port_idle_a: assert property (mode == OTPP_M_WRITE |=> !prog_data_port_oe_out)
    else $error("port driven during write");
  verify_data_a: assert property (mode == OTPP_M_VERIFY && sub_cnt == 2'h0 && in_range
                                  |=> prog_data_port_out == $past(mem[addr][7:0]))
    else $error("verify byte not the stored word");
  fetch_word_a: assert property (nrst_in && cpu_pc_in < OTPP_TEST_BASE
                                 |=> cpu_instr_out == $past(mem[cpu_pc_in]) && !cpu_redirect_out)
    else $error("fetched word not the stored word");
endmodule

// ==== sim/otpp_prog_model.sv ====
// Programmer model driving the programming pins of otpp_port.
// Assumes its tasks are called right after a clk_in rising edge.
`timescale 1ns/100ps
module otpp_prog_model
  import otpp_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic [7:0] dout_in,
  output logic [3:0]      mode_out,
  output logic [7:0]      data_out,
  output logic            adv_out,
  output logic            vdd_out,
  output logic            vpp_out,
  output logic            res_out
);
  logic        res_en    = 1'b1;
  int unsigned next_addr = 0;

  initial begin
    mode_out = 4'h0;
    data_out = 8'h00;
    adv_out  = 1'b0;
    vdd_out  = 1'b0;
    vpp_out  = 1'b0;
    res_out  = 1'b0;
  end

  // ----------------------------------------
  // Resonator, running unless stopped
  // ----------------------------------------
  always @(posedge clk_in) if (res_en) res_out <= ~res_out;

  task automatic hold(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic resonator(input logic on);
    res_en <= on;
    hold(1);
  endtask

  task automatic supply(input logic v, input logic p);
    vdd_out <= v;
    vpp_out <= p;
    hold(1);
  endtask

  task automatic pins(input logic [3:0] m, input logic [7:0] d, input int n);
    mode_out <= m;
    data_out <= d;
    hold(n);
  endtask

  task automatic advance(input int k);
    repeat (k) begin
      adv_out <= 1'b1;
      hold(2);
      adv_out <= 1'b0;
      hold(2);
    end
  endtask

  task automatic enter();
    adv_out <= 1'b0;
    vdd_out <= 1'b0;
    vpp_out <= 1'b0;
    hold(10);
    pins(OTPP_MD_CLEAR, 8'h00, 2);
    vdd_out <= 1'b1;
    vpp_out <= 1'b1;
    hold(2);
    pins(OTPP_MD_INH_VAL, 8'h00, 4);
  endtask

  // ----------------------------------------
  // Write, verify, extra write, then step
  // ----------------------------------------
  task automatic prog_word(input logic [9:0] w, output logic ok);
    logic [7:0] part;
    int         x;
    ok = 1'b1;
    if (next_addr >= 32'(OTPP_TEST_BASE)) return;
    for (int p = 0; p < 2; p++) begin
      part = (p == 1) ? {6'h00, w[9:8]} : w[7:0];
      x = 0;
      do begin
        x++;
        pins(OTPP_MD_WRITE, part, 10);
        pins(OTPP_MD_INH_VAL, part, 2);
        pins(OTPP_MD_VERIFY, ~part, 3);
      end while (dout_in !== part && x < 4);
      if (dout_in !== part) ok = 1'b0;
      pins(OTPP_MD_WRITE, part, 10 * x);
      pins(OTPP_MD_INH_VAL, part, 2);
      advance((p == 1) ? 3 : 1);
    end
    next_addr++;
  endtask
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench for otpp_port with a programmer model and AXI4-Lite master.
// Assumes otpp_pkg and otpp_prog_model are compiled first.
`timescale 1ns/100ps
module testbench
  import otpp_pkg::*;
;
  logic        clk_in, nrst_in, adv, vdd, vpp, res, res_o, act, oe, redir, ok;
  logic [3:0]  mode, wstrb;
  logic [7:0]  din, dout, awaddr, araddr;
  logic [9:0]  pc, instr;
  logic [31:0] wdata, rdata, r;
  logic [1:0]  bresp, rresp, rs;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          err_count   = 0;
  int          check_count = 0;
  localparam logic [6:0] MODE_ROWS [6] =
    '{{4'h5, 3'h1}, {4'he, 3'h2}, {4'hc, 3'h3}, {4'hd, 3'h4}, {4'hf, 3'h4}, {4'h9, 3'h0}};
  localparam logic [10:0] PC_ROWS [4] =
    '{{10'h000, 1'b0}, {10'h3e9, 1'b0}, {10'h3ea, 1'b1}, {10'h3ff, 1'b1}};

  otpp_port #(.HOLD_CYCLES(8)) dut (
    .clk_in(clk_in), .nrst_in(nrst_in),
    .prog_mode_select_in(mode), .prog_data_port_in(din),
    .prog_data_port_out(dout), .prog_data_port_oe_out(oe),
    .adv_clk_in(adv), .vdd_raised_in(vdd), .vpp_raised_in(vpp),
    .resonator_in(res), .resonator_out(res_o), .prog_active_out(act),
    .cpu_pc_in(pc), .cpu_instr_out(instr), .cpu_redirect_out(redir),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  otpp_prog_model pm (
    .clk_in(clk_in), .dout_in(dout), .mode_out(mode), .data_out(din),
    .adv_out(adv), .vdd_out(vdd), .vpp_out(vpp), .res_out(res)
  );

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Checks %0d, errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic stall();
    err_count++;
    wrap_up();
  endtask

  task automatic chk_port(input logic [7:0] e);
    @(negedge clk_in);
    chk({31'h0, oe}, 32'h1);
    chk({24'h0, dout}, {24'h0, e});
    @(posedge clk_in);
  endtask

  // ----------------------------------------
  // AXI4-Lite master
  // ----------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] resp);
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    {awvalid, wvalid, bready} <= 3'h7;
    for (int n = 0; n < 50; n++) begin
      @(posedge clk_in);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        return;
      end
    end
    stall();
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge clk_in);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    for (int n = 0; n < 50; n++) begin
      @(posedge clk_in);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        return;
      end
    end
    stall();
  endtask

  initial begin
    repeat (100000) @(posedge clk_in);
    stall();
  end

  initial begin
    nrst_in = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr} = 16'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    pc = 10'h000;
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    axi_rd(OTPP_OFS_CTRL, r, rs);
    chk(r, 32'h0);
    axi_rd(OTPP_OFS_ADDR, r, rs);
    chk(r, 32'h0);
    axi_rd(8'h10, r, rs);
    chk({30'h0, rs}, {30'h0, OTPP_RESP_SLVERR});
    pm.enter();
    axi_rd(OTPP_OFS_STATUS, r, rs);
    chk(r & 32'h37, 32'h24);
    chk({31'h0, act}, 32'h1);
    for (int i = 0; i < 6; i++) begin
      pm.pins(MODE_ROWS[i][6:3], 8'h00, 2);
      axi_rd(OTPP_OFS_STATUS, r, rs);
      chk(r & 32'h7, {29'h0, MODE_ROWS[i][2:0]});
    end
    axi_wr(8'h10, 32'h1, 4'hf, rs);
    chk({30'h0, rs}, {30'h0, OTPP_RESP_SLVERR});
    pm.pins(OTPP_MD_CLEAR, 8'h00, 2);
    pm.pins(OTPP_MD_INH_VAL, 8'h00, 2);
    pm.prog_word(10'h2a5, ok);
    chk({31'h0, ok}, 32'h1);
    pm.prog_word(10'h15a, ok);
    chk({31'h0, ok}, 32'h1);
    axi_rd(OTPP_OFS_ADDR, r, rs);
    chk(r, 32'h2);
    for (int i = 0; i < 4; i++) begin
      pc <= PC_ROWS[i][10:1];
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      chk({31'h0, redir}, {31'h0, PC_ROWS[i][0]});
      if (i == 0) chk({22'h0, instr}, 32'h2a5);
      @(posedge clk_in);
    end
    axi_wr(OTPP_OFS_CTRL, 32'h1, 4'h1, rs);
    chk({30'h0, rs}, {30'h0, OTPP_RESP_OKAY});
    pm.pins(OTPP_MD_CLEAR, 8'h00, 2);
    pm.pins(OTPP_MD_VERIFY, 8'h5c, 3);
    chk_port(8'ha5);
    pm.advance(1);
    chk_port(8'h02);
    pm.advance(3);
    chk_port(8'h5a);
    for (int i = 0; i < 3; i++) pm.advance(4);
    axi_rd(OTPP_OFS_STATUS, r, rs);
    chk(r & 32'h200, 32'h200);
    axi_rd(OTPP_OFS_CAPTURE, r, rs);
    chk(r, 32'h8000_02a5);
    for (int i = 0; i < 4 && r[31]; i++) axi_rd(OTPP_OFS_CAPTURE, r, rs);
    chk(r & 32'h8000_0000, 32'h0);
    axi_wr(OTPP_OFS_STATUS, 32'h200, 4'h2, rs);
    axi_rd(OTPP_OFS_STATUS, r, rs);
    chk(r & 32'h200, 32'h0);
    axi_wr(OTPP_OFS_CTRL, 32'h0, 4'h1, rs);
    axi_wr(OTPP_OFS_CTRL, 32'h1, 4'h2, rs);
    axi_rd(OTPP_OFS_CTRL, r, rs);
    chk(r, 32'h0);
    pm.pins(OTPP_MD_CLEAR, 8'h00, 2);
    pm.pins(OTPP_MD_INH_VAL, 8'h00, 2);
    pm.advance(2);
    pm.pins(OTPP_MD_CLEAR, 8'h00, 2);
    pm.pins(OTPP_MD_INH_VAL, 8'h00, 2);
    pm.advance(2);
    axi_rd(OTPP_OFS_ADDR, r, rs);
    chk(r, 32'h0002_0000);
    nrst_in <= 1'b0;
    pm.hold(3);
    chk({30'h0, act, oe}, 32'h0);
    nrst_in <= 1'b1;
    pm.supply(1'b1, 1'b0);
    pm.hold(12);
    axi_rd(OTPP_OFS_STATUS, r, rs);
    chk(r & 32'h30, 32'h0);
    pm.supply(1'b0, 1'b0);
    pm.hold(10);
    pm.supply(1'b0, 1'b1);
    pm.hold(3);
    axi_rd(OTPP_OFS_STATUS, r, rs);
    chk(r & 32'h30, 32'h10);
    pm.enter();
    pm.resonator(1'b0);
    pm.hold(12);
    pm.pins(OTPP_MD_WRITE, 8'hff, 10);
    pm.resonator(1'b1);
    pm.pins(OTPP_MD_INH_VAL, 8'h00, 2);
    pm.pins(OTPP_MD_VERIFY, 8'h00, 3);
    chk_port(8'h00);
    wrap_up();
  end
endmodule
